// ### hw/ilg_pkg.sv
package ilg_pkg;
   // ----------------------------------------
   // Control register layout
   // ----------------------------------------
   localparam int LVL_W = 3;
   localparam int ICR_LVL_LSB = 0;
   localparam int ICR_FLAG_BIT = 3;
   localparam int ICR_POL_BIT = 4;
   localparam logic [7:0] ICR_RESET = 8'h00;
   // ----------------------------------------
   // Sources, stack, port, low power
   // ----------------------------------------
   localparam int NUM_EXT = 3;
   localparam logic [19:0] ACK_ADDR = 20'h00000;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam int PORT8_NMI_BIT = 5;
   localparam logic [7:0] PORT8_RESET = 8'h00;
   localparam logic [2:0] PREFETCH_BYTES = 3'h4;
   typedef enum logic [1:0] {
      ILG_RUN, ILG_PREFETCH, ILG_WAIT_HALT, ILG_STOP_HALT
   } ilg_lp_e;
endpackage

// ### hw/ilg_pin_if.sv
`timescale 1ns/1ns
interface ilg_pin_if #(parameter int N = 3);
   logic [N-1:0] pin;
   logic [N-1:0] pol;
   logic [N-1:0] evt;
   modport det (input pin, input pol, output evt);
   modport ctl (output pin, output pol, input evt);
endinterface

// ### hw/ilg_pin_edge.sv
`timescale 1ns/1ns
module ilg_pin_edge
   import ilg_pkg::*;
#(
   parameter int N = NUM_EXT
)
(
   input wire logic clk,
   input wire logic rst_n,
   ilg_pin_if.det pif
);
   // ----------------------------------------
   // Edge detect on polarity-adjusted level
   // ----------------------------------------
   // A polarity flip changes the adjusted level, so it can look like an
   // edge and raise the request; software clears it afterwards.
   logic [N-1:0] eff_q;
   wire logic [N-1:0] eff = pif.pin ^ pif.pol;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         eff_q <= '0;
      else
         eff_q <= eff;
   end
   assign pif.evt = eff & ~eff_q;
   generate
      for (genvar g = 0; g < N; g++)
      begin : g_chk
         pol_flip_a: assert property (@(posedge clk)
            disable iff (!rst_n)
            $changed(pif.pol[g]) && $stable(pif.pin[g]) && eff_q[g] == 1'b0
            |-> pif.evt[g])
            else $error("polarity change did not raise request");
      end
   endgenerate
endmodule

// ### hw/ilg_core.sv
`timescale 1ns/1ns
// How it works
// - Acknowledge read returns source number and level
// - Acknowledge read clears served request flag
// - Software acknowledge read also clears winner flag
// - Stack pointer resets to zero
// - NMI has no mask, always requested
// - NMI pin readable as port bit
// - NMI low forces all-clock-stop bit zero
// - Wait with NMI low: halt, oscillator runs
// - Polarity change may set request flag
// - Request flag is bit 3, cleared by write
// - Four prefetched bytes before halting
// - Rewrite keeps concurrent request latched
module ilg_core
   import ilg_pkg::*;
#(
   parameter int NUM_SRC = 8,
   parameter int SEL_W = $clog2(NUM_SRC)
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [NUM_SRC-1:0] int_evt,
   input wire logic [NUM_EXT-1:0] external_interrupt_pins,
   input wire logic nmi_n,
   input wire logic icr_wr,
   input wire logic [SEL_W-1:0] icr_sel,
   input wire logic [7:0] icr_wdata,
   output logic [7:0] icr_rdata_q,
   input wire logic i_flag,
   input wire logic [LVL_W-1:0] cpu_ipl,
   output logic irq_req,
   output logic nmi_req,
   input wire logic nmi_ack,
   input wire logic ack_rd,
   input wire logic sw_ack_rd,
   output logic ack_valid_q,
   output logic [SEL_W+LVL_W-1:0] ack_data_q,
   input wire logic sp_wr,
   input wire logic [15:0] sp_wdata,
   output logic [15:0] sp_q,
   output logic [7:0] port_group_eight_data_q,
   input wire logic cm_wr,
   input wire logic cm_stop_wdata,
   input wire logic cm_wait_pstop_wdata,
   output logic all_clock_stop_bit_q,
   output logic wait_peripheral_clock_stop_bit_q,
   input wire logic wait_cmd,
   input wire logic prefetch_byte,
   output logic cpu_halt,
   output logic osc_enable
);
   // ----------------------------------------
   // Control registers and request flags
   // ----------------------------------------
   logic [7:0] icr_q [NUM_SRC];
   logic [NUM_SRC-1:0] flag_q;
   logic [NUM_SRC-1:0] set_vec;
   logic [NUM_SRC-1:0] win_oh;
   logic [SEL_W-1:0] win_idx;
   logic [LVL_W-1:0] win_lvl;
   logic [NUM_EXT-1:0] pol_vec;
   ilg_pin_if #(.N(NUM_EXT)) pif ();
   assign pif.pin = external_interrupt_pins;
   assign pif.pol = pol_vec;
   ilg_pin_edge #(.N(NUM_EXT)) u_edge (.clk(clk), .rst_n(rst_n), .pif(pif));

   function automatic logic [LVL_W-1:0] lvl_of(input logic [7:0] r);
      lvl_of = r[ICR_LVL_LSB +: LVL_W];
   endfunction

   wire logic ack_take = (ack_rd || sw_ack_rd) && (win_lvl != '0);
   generate
      for (genvar g = 0; g < NUM_SRC; g++)
      begin : g_src
         if (g < NUM_EXT)
         begin : g_ext
            assign set_vec[g] = int_evt[g] | pif.evt[g];
            assign pol_vec[g] = icr_q[g][ICR_POL_BIT];
         end
         else
         begin : g_int
            assign set_vec[g] = int_evt[g];
         end
         wire logic wr_me = icr_wr && (icr_sel == SEL_W'(g));
         // Set wins over a clear in the same cycle, whatever the write
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               flag_q[g] <= 1'b0;
            else if (set_vec[g])
               flag_q[g] <= 1'b1;
            else if (ack_take && win_oh[g])
               flag_q[g] <= 1'b0;
            else if (wr_me)
               flag_q[g] <= icr_wdata[ICR_FLAG_BIT];
         end
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               icr_q[g] <= ICR_RESET;
            else if (wr_me)
               icr_q[g] <= icr_wdata;
         end
         flag_clr_a: assert property (@(posedge clk)
            disable iff (!rst_n)
            wr_me && !icr_wdata[ICR_FLAG_BIT] && !set_vec[g]
            |=> !flag_q[g])
            else $error("request flag not cleared by write");
      end
   endgenerate

   // ----------------------------------------
   // Priority pick: highest level, lowest index on ties
   // ----------------------------------------
   always_comb
   begin
      win_idx = '0;
      win_lvl = '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (flag_q[i] && lvl_of(icr_q[i]) > win_lvl)
         begin
            win_idx = SEL_W'(i);
            win_lvl = lvl_of(icr_q[i]);
         end
      end
   end
   assign win_oh = NUM_SRC'(1) << win_idx;
   // Level zero means disabled; the interrupt flag gates only maskables
   assign irq_req = i_flag && (win_lvl > cpu_ipl);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_valid_q <= 1'b0;
         ack_data_q <= '0;
      end
      else
      begin
         ack_valid_q <= ack_rd || sw_ack_rd;
         if (ack_rd || sw_ack_rd)
            ack_data_q <= {win_idx, win_lvl};
      end
   end
   ack_data_a: assert property (@(posedge clk) disable iff (!rst_n)
      ack_rd |=> ack_valid_q
         && ack_data_q == {$past(win_idx), $past(win_lvl)})
      else $error("acknowledge data wrong");
   ack_clear_a: assert property (@(posedge clk)
      disable iff (!rst_n)
      ack_take |=> ((flag_q & $past(win_oh) & ~$past(set_vec)) == '0))
      else $error("served flag not cleared");

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         icr_rdata_q <= ICR_RESET;
      else
      begin
         icr_rdata_q <= icr_q[icr_sel];
         icr_rdata_q[ICR_FLAG_BIT] <= flag_q[icr_sel];
      end
   end

   // ----------------------------------------
   // Stack pointer and NMI
   // ----------------------------------------
   logic nmi_n_q;
   logic nmi_pend_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sp_q <= SP_RESET;
      else if (sp_wr)
         sp_q <= sp_wdata;
   end
   sp_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$past(rst_n) |-> sp_q == SP_RESET)
      else $error("stack pointer not zero after reset");

   wire logic nmi_fall = nmi_n_q && !nmi_n;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         nmi_n_q <= 1'b1;
         nmi_pend_q <= 1'b0;
         port_group_eight_data_q <= PORT8_RESET;
      end
      else
      begin
         nmi_n_q <= nmi_n;
         port_group_eight_data_q[PORT8_NMI_BIT] <= nmi_n;
         if (nmi_fall)
            nmi_pend_q <= 1'b1;
         else if (nmi_ack)
            nmi_pend_q <= 1'b0;
      end
   end
   assign nmi_req = nmi_pend_q;
   nmi_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
      nmi_fall |=> nmi_req)
      else $error("NMI edge not requested");
   port_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
      rst_n |=> port_group_eight_data_q[PORT8_NMI_BIT] == $past(nmi_n))
      else $error("port bit does not follow NMI pin");

   // ----------------------------------------
   // Wait and stop entry
   // ----------------------------------------
   // Halting waits for the queue to take its bytes; the CPU keeps
   // fetching meanwhile, so those bytes must be harmless padding.
   ilg_lp_e st_q;
   logic to_stop_q;
   logic [2:0] pf_cnt_q;
   wire logic stop_req = cm_wr && cm_stop_wdata && nmi_n;
   wire logic wake = irq_req || nmi_req;
   wire logic pf_done = prefetch_byte && pf_cnt_q == PREFETCH_BYTES - 3'h1;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= ILG_RUN;
         to_stop_q <= 1'b0;
         pf_cnt_q <= '0;
      end
      else
      begin
         case (st_q)
            ILG_RUN:
               if (wait_cmd || stop_req)
               begin
                  st_q <= ILG_PREFETCH;
                  to_stop_q <= stop_req;
                  pf_cnt_q <= '0;
               end
            ILG_PREFETCH:
               if (to_stop_q && !nmi_n)
                  st_q <= ILG_RUN;
               else if (prefetch_byte)
               begin
                  pf_cnt_q <= pf_cnt_q + 3'h1;
                  if (pf_done)
                     st_q <= to_stop_q ? ILG_STOP_HALT : ILG_WAIT_HALT;
               end
            ILG_WAIT_HALT, ILG_STOP_HALT:
               if (wake || (st_q == ILG_STOP_HALT && !nmi_n))
                  st_q <= ILG_RUN;
            default:
               st_q <= ILG_RUN;
         endcase
      end
   end
   assign cpu_halt = (st_q == ILG_WAIT_HALT) || (st_q == ILG_STOP_HALT);
   assign osc_enable = (st_q != ILG_STOP_HALT);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         all_clock_stop_bit_q <= 1'b0;
         wait_peripheral_clock_stop_bit_q <= 1'b0;
      end
      else
      begin
         if (cm_wr)
            wait_peripheral_clock_stop_bit_q <= cm_wait_pstop_wdata;
         if (!nmi_n || st_q == ILG_RUN && !stop_req && !wait_cmd)
            all_clock_stop_bit_q <= 1'b0;
         if (stop_req)
            all_clock_stop_bit_q <= 1'b1;
      end
   end
   stop_block_a: assert property (@(posedge clk) disable iff (!rst_n)
      !nmi_n |=> !all_clock_stop_bit_q && st_q != ILG_STOP_HALT)
      else $error("stop entered with NMI low");
   wait_osc_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == ILG_WAIT_HALT |-> osc_enable && cpu_halt)
      else $error("oscillator stopped in wait");
   prefetch_a: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == ILG_RUN && (wait_cmd || stop_req)) ##1 prefetch_byte [*3]
      |=> !cpu_halt)
      else $error("halted before four prefetch bytes");
endmodule

// ### tb/ilg_src_model.sv
`timescale 1ns/1ns
module ilg_src_model
   import ilg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic nmi_req,
   input wire logic [NUM_EXT-1:0] pin_cmd,
   input wire logic nmi_cmd,
   input wire logic [3:0] ack_delay,
   output logic [NUM_EXT-1:0] pins,
   output logic nmi_n,
   output logic nmi_ack
);
   // ----------------------------------------
   // Pins, quiet while the first fetch runs
   // ----------------------------------------
   logic [3:0] quiet_q;
   logic [3:0] wait_q;
   // Pull-up keeps the NMI line high when idle
   assign pins = (quiet_q != 4'h0) ? '0 : pin_cmd;
   assign nmi_n = (quiet_q != 4'h0) ? 1'b1 : !nmi_cmd;
   // ----------------------------------------
   // CPU side, serves NMI after a delay
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         quiet_q <= 4'h4;
         wait_q <= 4'h0;
         nmi_ack <= 1'b0;
      end
      else
      begin
         nmi_ack <= 1'b0;
         if (quiet_q != 4'h0)
            quiet_q <= quiet_q - 4'h1;
         if (nmi_req && !nmi_ack)
         begin
            wait_q <= (wait_q == ack_delay) ? 4'h0 : wait_q + 4'h1;
            nmi_ack <= (wait_q == ack_delay);
         end
      end
   end
endmodule

// ### tb/ilg_core_tb.sv
`timescale 1ns/1ns
module ilg_core_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] int_evt, icr_wdata, icr_rdata_q, port_q;
   logic [2:0] pin_cmd, ext_pins, icr_sel, cpu_ipl;
   logic nmi_cmd, nmi_n, nmi_req, nmi_ack, icr_wr, i_flag, irq_req;
   logic ack_rd, sw_ack_rd, ack_valid_q, sp_wr, cm_wr, cm_stop, cm_pstop;
   logic wait_cmd, pf, cpu_halt, osc_enable, stop_q, pstop_q;
   logic [5:0] ack_data_q;
   logic [15:0] sp_wdata, sp_q;
   logic [3:0] ack_delay;
   int n_fail = 0;
   int samples_checked = 0;
   int i;
   always #50 clk = ~clk;
   ilg_src_model pm (.clk(clk), .rst_n(rst_n), .nmi_req(nmi_req),
      .pin_cmd(pin_cmd), .nmi_cmd(nmi_cmd), .ack_delay(ack_delay),
      .pins(ext_pins), .nmi_n(nmi_n), .nmi_ack(nmi_ack));
   ilg_core uut (.clk(clk), .rst_n(rst_n), .int_evt(int_evt),
      .external_interrupt_pins(ext_pins), .nmi_n(nmi_n), .icr_wr(icr_wr),
      .icr_sel(icr_sel), .icr_wdata(icr_wdata), .icr_rdata_q(icr_rdata_q),
      .i_flag(i_flag), .cpu_ipl(cpu_ipl), .irq_req(irq_req),
      .nmi_req(nmi_req), .nmi_ack(nmi_ack), .ack_rd(ack_rd),
      .sw_ack_rd(sw_ack_rd), .ack_valid_q(ack_valid_q),
      .ack_data_q(ack_data_q), .sp_wr(sp_wr), .sp_wdata(sp_wdata),
      .sp_q(sp_q), .port_group_eight_data_q(port_q), .cm_wr(cm_wr),
      .cm_stop_wdata(cm_stop), .cm_wait_pstop_wdata(cm_pstop),
      .all_clock_stop_bit_q(stop_q),
      .wait_peripheral_clock_stop_bit_q(pstop_q), .wait_cmd(wait_cmd),
      .prefetch_byte(pf), .cpu_halt(cpu_halt), .osc_enable(osc_enable));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Bounded waits end the run instead of hanging
   task automatic bound(input logic ok);
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t wait ran out", $time);
         finish_test();
      end
   endtask
   task automatic wr_icr(input logic [2:0] s, input logic [7:0] d);
      @(posedge clk) icr_sel <= s;
      icr_wdata <= d;
      icr_wr <= 1'b1;
      @(posedge clk) icr_wr <= 1'b0;
   endtask
   task automatic flag(input logic [2:0] s, input logic e);
      @(posedge clk) icr_sel <= s;
      repeat (2) @(posedge clk);
      @(negedge clk) chk(icr_rdata_q[3], e);
   endtask
   task automatic ack(input logic sw, input logic [5:0] e);
      @(posedge clk) ack_rd <= !sw;
      sw_ack_rd <= sw;
      @(posedge clk) ack_rd <= 1'b0;
      sw_ack_rd <= 1'b0;
      @(negedge clk) chk(ack_valid_q, 1'b1);
      chk(ack_data_q, e);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      @(negedge clk) chk(sp_q, 16'h0000);
      chk(nmi_req, 1'b0);
      chk({cpu_halt, osc_enable, stop_q}, 3'h2);
      chk(port_q[5], 1'b1);
      @(posedge clk) sp_wr <= 1'b1;
      @(posedge clk) sp_wr <= 1'b0;
      @(negedge clk) chk(sp_q, 16'h1234);
      $display("test reset done");
   endtask
   task automatic t_ack();
      wr_icr(3'h5, 8'h03);
      wr_icr(3'h6, 8'h05);
      @(posedge clk) int_evt <= 8'h60;
      @(posedge clk) int_evt <= 8'h00;
      ack(1'b0, {3'h6, 3'h5});
      flag(3'h6, 1'b0);
      flag(3'h5, 1'b1);
      chk(icr_rdata_q, 16'h000b);
      ack(1'b1, {3'h5, 3'h3});
      flag(3'h5, 1'b0);
      ack(1'b0, 6'h00);
      $display("test acknowledge done");
   endtask
   task automatic t_pol();
      wr_icr(3'h0, 8'h01);
      wr_icr(3'h0, 8'h11);
      wr_icr(3'h0, 8'h11);
      flag(3'h0, 1'b0);
      // Both edges go by, so either polarity must fire
      @(posedge clk) pin_cmd <= 3'h1;
      repeat (3) @(posedge clk);
      pin_cmd <= 3'h0;
      flag(3'h0, 1'b1);
      wr_icr(3'h0, 8'h00);
      flag(3'h0, 1'b0);
      $display("test polarity done");
   endtask
   task automatic t_nmi();
      @(posedge clk) nmi_cmd <= 1'b1;
      for (i = 0; i < 4 && nmi_req !== 1'b1; i++) @(negedge clk);
      bound(nmi_req);
      chk(port_q[5], 1'b0);
      @(posedge clk) cm_wr <= 1'b1;
      @(posedge clk) cm_wr <= 1'b0;
      @(negedge clk) chk({stop_q, pstop_q, osc_enable}, 3'h3);
      for (i = 0; i < 16 && nmi_req !== 1'b0; i++) @(negedge clk);
      bound(!nmi_req);
      @(posedge clk) wait_cmd <= 1'b1;
      @(posedge clk) wait_cmd <= 1'b0;
      pf <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk) chk(cpu_halt, 1'b0);
      @(posedge clk) pf <= 1'b0;
      for (i = 0; i < 3 && cpu_halt !== 1'b1; i++) @(negedge clk);
      chk({cpu_halt, osc_enable}, 2'h3);
      wr_icr(3'h7, 8'h02);
      repeat (2) @(posedge clk);
      @(posedge clk) i_flag <= 1'b1;
      int_evt <= 8'h80;
      @(posedge clk) int_evt <= 8'h00;
      for (i = 0; i < 4 && cpu_halt !== 1'b0; i++) @(negedge clk);
      bound(!cpu_halt);
      chk(irq_req, 1'b1);
      ack(1'b0, {3'h7, 3'h2});
      @(posedge clk) nmi_cmd <= 1'b0;
      repeat (2) @(posedge clk);
      // NMI line is back high, so stop entry is legal
      cm_wr <= 1'b1;
      @(posedge clk) cm_wr <= 1'b0;
      pf <= 1'b1;
      @(negedge clk) chk(stop_q, 1'b1);
      repeat (3) @(posedge clk);
      @(negedge clk) chk(cpu_halt, 1'b0);
      @(posedge clk) pf <= 1'b0;
      @(negedge clk) chk({cpu_halt, osc_enable}, 2'h2);
      @(posedge clk) nmi_cmd <= 1'b1;
      @(posedge clk);
      @(negedge clk) chk({cpu_halt, osc_enable, stop_q}, 3'h2);
      $display("test nmi and low power done");
   endtask
   initial
   begin
      {int_evt, icr_wdata, pin_cmd, icr_sel, cpu_ipl} = '0;
      {nmi_cmd, icr_wr, i_flag, ack_rd, sw_ack_rd, sp_wr} = '0;
      {cm_wr, wait_cmd, pf} = '0;
      {cm_stop, cm_pstop} = 2'h3;
      sp_wdata = 16'h1234;
      ack_delay = 4'h6;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
      t_ack();
      t_pol();
      t_nmi();
      finish_test();
   end
endmodule
